// *** hdl/sar_adc_pkg.sv ***
package sar_adc_pkg;

  // ----------------------------------------
  // register map
  // ----------------------------------------
  localparam logic [15:0] RESULT_WORD_ADDR = 16'hff06;
  localparam logic [15:0] RESULT_HIGH_ADDR = 16'hff07;
  localparam logic [15:0] MODE_ADDR = 16'hff8d;
  localparam logic [7:0] MODE_RESET = 8'h00;
  localparam logic [15:0] RESULT_RESET = 16'h0000;
  localparam logic [7:0] HIGH_BYTE_RESET = 8'h00;

  // ----------------------------------------
  // converter_mode fields
  // ----------------------------------------
  localparam int RUN_BIT = 7;
  localparam int DIV_LSB = 3;
  localparam int TS_LSB = 1;
  localparam int CE_BIT = 0;
  localparam logic [1:0] TS_NORMAL = 2'h0;
  localparam logic [1:0] TS_LOW = 2'h1;

  // ----------------------------------------
  // conversion lengths in conversion-clock periods
  // ----------------------------------------
  localparam logic [5:0] STEPS_NORMAL = 6'h16;
  localparam logic [5:0] STEPS_LOW = 6'h28;

  typedef enum logic [1:0] {
    ST_IDLE = 2'h0,
    ST_SAMPLE = 2'h1,
    ST_CONVERT = 2'h3
  } conv_state_t;

  // divisor 0 marks a prohibited setting
  function automatic logic [4:0] divisor_of(input logic [3:0] div, input logic [1:0] ts);
    logic [4:0] d;
    d = 5'h00;
    case (div)
      4'h0: d = 5'h0c;
      4'h1: d = 5'h08;
      4'h2: d = 5'h06;
      4'h3: d = 5'h04;
      4'h4: d = 5'h03;
      4'h5: d = 5'h02;
      default: d = (div[3] && ts == TS_NORMAL) ? 5'h10 : 5'h00;
    endcase
    if (ts != TS_NORMAL && ts != TS_LOW) begin
      d = 5'h00;
    end
    return d;
  endfunction : divisor_of

endpackage : sar_adc_pkg

// *** hdl/sar_adc_mode_and_result.sv ***
`timescale 1ns/1ns

module sar_adc_mode_and_result #(
  parameter int RES_BITS = 10
) (
  // clock and reset
  input wire logic clk_i,
  input wire logic reset_i,
  // cpu bus
  input wire logic bus_req_i,
  input wire logic bus_we_i,
  input wire logic [15:0] bus_addr_i,
  input wire logic [15:0] bus_wdata_i,
  input wire logic [7:0] bus_bitmask_i,
  output logic [15:0] bus_rdata_o,
  output logic bus_ready_o,
  // analogue side
  input wire logic comparator_i,
  output logic sample_hold_o,
  output logic comparator_power_o,
  output logic [RES_BITS-1:0] trial_code_o,
  // results
  output logic conversion_done_irq_o,
  output logic [7:0] result_high_byte_o
);

  if (RES_BITS < 8 || RES_BITS > 16) begin : g_bad_width
    $error("RES_BITS must be 8 to 16");
  end

  // ----------------------------------------
  // mode decode
  // ----------------------------------------
  logic [7:0] converter_mode_r;
  logic [15:0] result_word_r;
  logic conversion_run;
  logic comparator_enable;
  logic [3:0] clock_divider;
  logic [1:0] timing_set;
  logic [4:0] divisor;
  logic [5:0] steps;
  logic [5:0] sample_ticks;

  assign conversion_run = converter_mode_r[sar_adc_pkg::RUN_BIT];
  assign comparator_enable = converter_mode_r[sar_adc_pkg::CE_BIT];
  assign clock_divider = converter_mode_r[sar_adc_pkg::DIV_LSB +: 4];
  assign timing_set = converter_mode_r[sar_adc_pkg::TS_LSB +: 2];
  assign divisor = sar_adc_pkg::divisor_of(clock_divider, timing_set);
  assign steps = (timing_set == sar_adc_pkg::TS_LOW) ? sar_adc_pkg::STEPS_LOW
                                                      : sar_adc_pkg::STEPS_NORMAL;
  assign sample_ticks = steps - 6'(RES_BITS);

  // ----------------------------------------
  // cpu bus slave
  // ----------------------------------------
  logic wait_r;
  logic taken;
  logic waited;

  assign taken = bus_req_i && !wait_r && !bus_ready_o;
  assign waited = (bus_we_i && bus_addr_i == sar_adc_pkg::MODE_ADDR) ||
                  (!bus_we_i && (bus_addr_i == sar_adc_pkg::RESULT_WORD_ADDR ||
                                 bus_addr_i == sar_adc_pkg::RESULT_HIGH_ADDR));

  // one wait cycle for mode writes and result reads
  always_ff @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      wait_r <= 1'b0;
      bus_ready_o <= 1'b0;
      bus_rdata_o <= 16'h0000;
    end else begin
      bus_ready_o <= wait_r || (taken && !waited);
      wait_r <= taken && waited;
      if (taken && !bus_we_i) begin
        // word read; the odd address gives the high byte alone
        case (bus_addr_i)
          sar_adc_pkg::RESULT_WORD_ADDR: bus_rdata_o <= result_word_r;
          sar_adc_pkg::RESULT_HIGH_ADDR: bus_rdata_o <= {8'h00, result_word_r[15:8]};
          sar_adc_pkg::MODE_ADDR: bus_rdata_o <= {8'h00, converter_mode_r};
          default: bus_rdata_o <= 16'h0000;
        endcase
      end
    end
  end

  // bit writes use the mask, byte writes set it all ones
  always_ff @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      converter_mode_r <= sar_adc_pkg::MODE_RESET;
    end else if (taken && bus_we_i && bus_addr_i == sar_adc_pkg::MODE_ADDR) begin
      converter_mode_r <= (converter_mode_r & ~bus_bitmask_i) |
                          (bus_wdata_i[7:0] & bus_bitmask_i);
    end
  end

  // ----------------------------------------
  // comparator capture
  // ----------------------------------------
  // the comparator only answers the trial code launched from this clock, so it
  // settles within a cycle; a second stage would miss the decision at /2
  logic comp_r;

  always_ff @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      comp_r <= 1'b0;
    end else begin
      comp_r <= comparator_i;
    end
  end

  // comparator powered while either bit is set
  always_ff @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      comparator_power_o <= 1'b0;
    end else begin
      comparator_power_o <= conversion_run || comparator_enable;
    end
  end

  // ----------------------------------------
  // conversion clock and sequence
  // ----------------------------------------
  sar_adc_pkg::conv_state_t state_r;
  logic [4:0] div_cnt_r;
  logic [5:0] phase_cnt_r;
  logic [RES_BITS-1:0] sar_r;
  logic [RES_BITS-1:0] bit_r;
  logic [RES_BITS-1:0] final_code;
  logic active;
  logic tick;
  logic enter_convert;
  logic done;

  // a prohibited setting is treated as stopped
  assign active = conversion_run && divisor != 5'h00;
  assign tick = state_r != sar_adc_pkg::ST_IDLE && div_cnt_r == divisor - 5'h01;
  assign enter_convert = active && state_r == sar_adc_pkg::ST_SAMPLE && tick &&
                         phase_cnt_r == sample_ticks - 6'h01;
  assign done = active && state_r == sar_adc_pkg::ST_CONVERT && tick && bit_r[0];
  assign final_code = comp_r ? sar_r : (sar_r & ~bit_r);

  always_ff @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      div_cnt_r <= 5'h00;
    end else if (!active || state_r == sar_adc_pkg::ST_IDLE || tick) begin
      div_cnt_r <= 5'h00;
    end else begin
      div_cnt_r <= div_cnt_r + 5'h01;
    end
  end

  always_ff @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      phase_cnt_r <= 6'h00;
    end else if (!active || enter_convert || done || state_r == sar_adc_pkg::ST_IDLE) begin
      phase_cnt_r <= 6'h00;
    end else if (tick) begin
      phase_cnt_r <= phase_cnt_r + 6'h01;
    end
  end

  // sample, approximate, repeat while run is set
  always_ff @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      state_r <= sar_adc_pkg::ST_IDLE;
      sample_hold_o <= 1'b0;
    end else if (!active) begin
      state_r <= sar_adc_pkg::ST_IDLE;
      sample_hold_o <= 1'b0;
    end else begin
      case (state_r)
        sar_adc_pkg::ST_IDLE: begin
          state_r <= sar_adc_pkg::ST_SAMPLE;
          sample_hold_o <= 1'b1;
        end
        sar_adc_pkg::ST_SAMPLE: begin
          if (enter_convert) begin
            state_r <= sar_adc_pkg::ST_CONVERT;
            sample_hold_o <= 1'b0;
          end
        end
        sar_adc_pkg::ST_CONVERT: begin
          if (done) begin
            state_r <= sar_adc_pkg::ST_SAMPLE;
            sample_hold_o <= 1'b1;
          end
        end
        default: begin
          state_r <= sar_adc_pkg::ST_IDLE;
          sample_hold_o <= 1'b0;
        end
      endcase
    end
  end

  // msb first, keep the trial bit when the input is above it
  always_ff @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      sar_r <= '0;
      bit_r <= '0;
    end else if (!active || state_r == sar_adc_pkg::ST_IDLE) begin
      sar_r <= '0;
      bit_r <= '0;
    end else if (enter_convert) begin
      sar_r <= {1'b1, {(RES_BITS-1){1'b0}}};
      bit_r <= {1'b1, {(RES_BITS-1){1'b0}}};
    end else if (state_r == sar_adc_pkg::ST_CONVERT && tick) begin
      sar_r <= final_code | (bit_r >> 1);
      bit_r <= bit_r >> 1;
    end
  end

  assign trial_code_o = sar_r;

  // ----------------------------------------
  // result registers
  // ----------------------------------------
  // left-justified load and completion pulse
  always_ff @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      result_word_r <= sar_adc_pkg::RESULT_RESET;
      result_high_byte_o <= sar_adc_pkg::HIGH_BYTE_RESET;
      conversion_done_irq_o <= 1'b0;
    end else begin
      conversion_done_irq_o <= done;
      if (done) begin
        result_word_r <= {final_code, {(16-RES_BITS){1'b0}}};
        result_high_byte_o <= final_code[RES_BITS-1 -: 8];
      end
    end
  end

  // ----------------------------------------
  // checks
  // ----------------------------------------
  logic [9:0] conv_cyc_r;

  always_ff @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      conv_cyc_r <= 10'h000;
    end else if (!active || state_r == sar_adc_pkg::ST_IDLE || done) begin
      conv_cyc_r <= 10'h000;
    end else begin
      conv_cyc_r <= conv_cyc_r + 10'h001;
    end
  end

  property p_length;
    @(posedge clk_i) disable iff (reset_i)
      done |-> conv_cyc_r == 10'(divisor) * 10'(steps) - 10'h001;
  endproperty
  a_length: assert property (p_length) else $error("conversion length wrong");

  property p_stop;
    @(posedge clk_i) disable iff (reset_i)
      !conversion_run |=> state_r == sar_adc_pkg::ST_IDLE && !sample_hold_o;
  endproperty
  a_stop: assert property (p_stop) else $error("conversion not stopped");

  property p_power_off;
    @(posedge clk_i) disable iff (reset_i)
      (!conversion_run && !comparator_enable) [*2] |-> !comparator_power_o;
  endproperty
  a_power_off: assert property (p_power_off) else $error("comparator powered");

  property p_wait_only;
    @(posedge clk_i) disable iff (reset_i)
      !conversion_run && comparator_enable ##1 !conversion_run && comparator_enable
        |-> comparator_power_o && !conversion_done_irq_o;
  endproperty
  a_wait_only: assert property (p_wait_only) else $error("waiting mode wrong");

  property p_abort;
    @(posedge clk_i) disable iff (reset_i)
      !conversion_run |=> !conversion_done_irq_o ##1 $stable(result_word_r);
  endproperty
  a_abort: assert property (p_abort) else $error("abort updated result");

  property p_load;
    @(posedge clk_i) disable iff (reset_i)
      conversion_done_irq_o |-> result_high_byte_o == result_word_r[15:8] &&
        result_word_r[15-:RES_BITS] == $past(final_code) && result_word_r[5:0] == 6'h00;
  endproperty
  a_load: assert property (p_load) else $error("result load wrong");

  property p_step;
    @(posedge clk_i) disable iff (reset_i)
      active && state_r == sar_adc_pkg::ST_CONVERT && tick && !bit_r[0] |=>
        bit_r == ($past(bit_r) >> 1);
  endproperty
  a_step: assert property (p_step) else $error("approximation order wrong");

  property p_read_wait;
    @(posedge clk_i) disable iff (reset_i)
      taken && !bus_we_i && bus_addr_i == sar_adc_pkg::RESULT_WORD_ADDR |=>
        !bus_ready_o ##1 bus_ready_o && bus_rdata_o == $past(result_word_r, 2);
  endproperty
  a_read_wait: assert property (p_read_wait) else $error("result read wait wrong");

  property p_write_wait;
    @(posedge clk_i) disable iff (reset_i)
      taken && bus_we_i && bus_addr_i == sar_adc_pkg::MODE_ADDR |=>
        !bus_ready_o ##1 bus_ready_o;
  endproperty
  a_write_wait: assert property (p_write_wait) else $error("mode write wait wrong");

endmodule : sar_adc_mode_and_result

// *** verification/analog_front_model.sv ***
`timescale 1ns/1ns

module analog_front_model (
  // analogue input
  input wire logic clk_i,
  input wire logic [9:0] level_i,
  // from converter
  input wire logic sample_hold_i,
  input wire logic power_i,
  input wire logic [9:0] trial_i,
  // to converter
  output logic comparator_o
);
  logic [9:0] held_r = 10'h000;
  logic idle_r = 1'b0;

  always_ff @(posedge clk_i) begin
    if (sample_hold_i) begin
      held_r <= level_i;
    end
    idle_r <= ~idle_r;
  end

  assign comparator_o = power_i ? (held_r >= trial_i) : idle_r;
endmodule : analog_front_model

// *** verification/tb.sv ***
`timescale 1ns/1ns

module tb;
  logic clk_i = 1'b0;
  logic reset_i = 1'b1;
  logic bus_req_i = 1'b0;
  logic bus_we_i = 1'b0;
  logic [15:0] bus_addr_i = 16'h0000;
  logic [15:0] bus_wdata_i = 16'h0000;
  logic [7:0] bus_bitmask_i = 8'h00;
  logic [15:0] bus_rdata_o;
  logic bus_ready_o;
  logic comparator_i;
  logic sample_hold_o;
  logic comparator_power_o;
  logic [9:0] trial_code_o;
  logic conversion_done_irq_o;
  logic [7:0] result_high_byte_o;
  logic [9:0] level = 10'h000;
  logic [15:0] rd;
  int err_total = 0;
  int checked = 0;
  int lat;
  int lat0;
  int n;
  // model comparator has no speed limit, so every legal divider is run
  logic [7:0] modes [13] = '{8'hc1, 8'h81, 8'h89, 8'h91, 8'h99, 8'ha1, 8'ha9,
                             8'h83, 8'h8b, 8'h93, 8'h9b, 8'ha3, 8'hab};
  int lens [13] = '{352, 264, 176, 132, 88, 66, 44, 480, 320, 240, 160, 120, 80};
  logic [7:0] bad [3] = '{8'hb1, 8'hc3, 8'h85};

  sar_adc_mode_and_result DUT (.clk_i(clk_i), .reset_i(reset_i), .bus_req_i(bus_req_i),
    .bus_we_i(bus_we_i), .bus_addr_i(bus_addr_i), .bus_wdata_i(bus_wdata_i),
    .bus_bitmask_i(bus_bitmask_i), .bus_rdata_o(bus_rdata_o), .bus_ready_o(bus_ready_o),
    .comparator_i(comparator_i), .sample_hold_o(sample_hold_o),
    .comparator_power_o(comparator_power_o), .trial_code_o(trial_code_o),
    .conversion_done_irq_o(conversion_done_irq_o), .result_high_byte_o(result_high_byte_o));

  analog_front_model front (.clk_i(clk_i), .level_i(level), .sample_hold_i(sample_hold_o),
    .power_i(comparator_power_o), .trial_i(trial_code_o), .comparator_o(comparator_i));

  // ----------------
  // helpers
  // ----------------
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      err_total++;
      $display("Error at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : check

  // request held until ready seen, released one cycle later
  task automatic access(input logic we, input logic [15:0] a, input logic [15:0] d,
                        input logic [7:0] m);
    @(negedge clk_i);
    bus_we_i = we;
    bus_addr_i = a;
    bus_wdata_i = d;
    bus_bitmask_i = m;
    bus_req_i = 1'b1;
    lat = 0;
    do begin
      @(negedge clk_i);
      lat++;
    end while (bus_ready_o !== 1'b1 && lat < 20);
    rd = bus_rdata_o;
    @(negedge clk_i);
    bus_req_i = 1'b0;
  endtask : access

  task automatic wait_done(input int max);
    n = 0;
    do begin
      @(negedge clk_i);
      n++;
    end while (conversion_done_irq_o !== 1'b1 && n < max);
  endtask : wait_done

  // stop, let the comparator settle, then start
  task automatic start(input logic [7:0] mode);
    access(1'b1, sar_adc_pkg::MODE_ADDR, 16'h0001, 8'hff);
    // 1 us of comparator enable first
    repeat (50) @(negedge clk_i);
    access(1'b1, sar_adc_pkg::MODE_ADDR, {8'h00, mode}, 8'hff);
  endtask : start

  task automatic test_done();
    if (err_total == 0 && checked > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask : test_done

  // ----------------
  // scenarios
  // ----------------
  task automatic t_reset();
    access(1'b0, sar_adc_pkg::MODE_ADDR, 16'h0000, 8'h00);
    check(rd, 16'h0000);
    lat0 = lat;
    access(1'b0, sar_adc_pkg::RESULT_WORD_ADDR, 16'h0000, 8'h00);
    check(rd, 16'h0000);
    check(lat, lat0 + 1);
    check(result_high_byte_o, 8'h00);
    access(1'b1, 16'hff10, 16'hffff, 8'hff);
    access(1'b0, 16'hff10, 16'h0000, 8'h00);
    check(rd, 16'h0000);
    access(1'b1, sar_adc_pkg::MODE_ADDR, 16'h0000, 8'hff);
    check(lat, lat0 + 1);
  endtask : t_reset

  // every legal divider and timing set, two back-to-back conversions each
  task automatic t_table();
    for (int i = 0; i < 13; i++) begin
      level = 10'(i * 77 + 5);
      start(modes[i]);
      wait_done(1000);
      wait_done(1000);
      check(n, lens[i]);
      check(result_high_byte_o, level[9:2]);
      // read result before next mode write
      access(1'b0, sar_adc_pkg::RESULT_WORD_ADDR, 16'h0000, 8'h00);
      check(rd, {level, 6'h00});
    end
    access(1'b0, sar_adc_pkg::RESULT_HIGH_ADDR, 16'h0000, 8'h00);
    check(rd, {8'h00, level[9:2]});
  endtask : t_table

  task automatic t_bad_and_abort();
    for (int i = 0; i < 3; i++) begin
      start(bad[i]);
      wait_done(600);
      check(n, 600);
    end
    level = 10'h155;
    start(8'h81);
    repeat (100) @(negedge clk_i);
    access(1'b1, sar_adc_pkg::MODE_ADDR, 16'h0001, 8'hff);
    wait_done(600);
    check(n, 600);
    check(result_high_byte_o, 8'he8);
    check(comparator_power_o, 1'b1);
    check(sample_hold_o, 1'b0);
  endtask : t_bad_and_abort

  // single-bit writes leave the other bits alone
  task automatic t_bits();
    access(1'b1, sar_adc_pkg::MODE_ADDR, 16'h0000, 8'h01);
    check(comparator_power_o, 1'b0);
    access(1'b1, sar_adc_pkg::MODE_ADDR, 16'h0080, 8'h80);
    access(1'b0, sar_adc_pkg::MODE_ADDR, 16'h0000, 8'h00);
    check(rd, 16'h0080);
    check(comparator_power_o, 1'b1);
    // first result without comparator enable discarded
    wait_done(1000);
    wait_done(1000);
    check(n, 264);
    check(result_high_byte_o, 8'h55);
    access(1'b1, sar_adc_pkg::MODE_ADDR, 16'h0000, 8'hff);
  endtask : t_bits

  initial begin
    forever #10 clk_i = ~clk_i;
  end

  initial begin
    repeat (16) @(posedge clk_i);
    @(negedge clk_i);
    reset_i = 1'b0;
    t_reset();
    t_table();
    t_bad_and_abort();
    t_bits();
    test_done();
  end

  // longest path is about 9200 cycles
  initial begin
    repeat (60000) @(posedge clk_i);
    err_total++;
    test_done();
  end
endmodule : tb
